// >>> core/charger_fault_status_supervisor.sv
// Protection and status supervisor of a single-cell charger
// Assumes all condition inputs synchronous to ref_clk
//
// Notes on behaviour
// - Status pin pulled low while charging; released when done, disabled or asleep.
// - Charge or boost suspend makes the status pin blink at one hertz.
// - Host raising the switch-off control opens the battery switch: shipping mode.
// - Shipping mode ends on adapter attach or wake pin falling edge.
// - Input limit is min of pin and setting; open pin zero, grounded pin setting.
// - Pin-limit enable low disables pin limit and its monitoring.
// - Thermal regulation stops termination, halves timer rate, sets its flag.
// - Buck thermal shutdown stops converter, opens switch, fault 10, interrupt.
// - Boost thermal shutdown clears boost enable, opens switch until cooled.
// - Input over-voltage stops switching, fault 01, interrupt.
// - System rail over-voltage halts the converter.
// - Boost over-current runs hiccup mode, sets boost fault, interrupt.
// - Boost over-voltage stops switching, clears boost enable, boost fault, interrupt.
// - Battery over-voltage disables charging, sets battery fault, interrupt.
// - Over-discharge opens battery switch until an input source appears.
// - System short latches switch open until shipping exit.
// - Warm charge voltage is nominal or nominal less fixed offset, by config bit.
// - Cool charge current is a fifth or half of fast charge, by config bit.
// - Thermistor fault shows live field, interrupt, and status pin while suspended.
// - Discharge stops outside the selectable cold/hot thermistor window.
// - Serial bus slave at fixed seven-bit address, standard and fast rate.
`timescale 1ns/1ps
module charger_fault_status_supervisor
  import charger_supervisor_pkg::*;
#(
  parameter int LIMIT_W           = 8,
  parameter int BLINK_HALF_CYCLES = `CLK_HZ / (2 * `BLINK_FREQ_HZ)
)(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire chargeState_t       chargeState,
  input  wire faultEvents_t       faults,
  input  wire logic               adapterPresent,
  input  wire logic               wakeRequestPin,
  input  wire logic               batterySwitchOffCtl,
  input  wire logic               boostEnableSet,
  input  wire logic               pinLimitEnable,
  input  wire logic               pinOpen,
  input  wire logic               pinGrounded,
  input  wire logic [LIMIT_W-1:0] pinLimit,
  input  wire logic [LIMIT_W-1:0] inputLimitSetting,
  input  wire logic               warmVoltageSel,
  input  wire logic               coolCurrentSel,
  input  wire logic [15:0]        chargeVoltageTarget,
  input  wire logic [15:0]        fastChargeCurrent,
  input  wire logic [2:0]         thermistorZone,
  input  wire logic [7:0]         ntcCode,
  input  wire logic [7:0]         dischargeColdThr,
  input  wire logic [7:0]         dischargeHotThr,
  input  wire logic               sclIn,
  input  wire logic               sdaIn,
  output logic                    sdaOut,
  output logic                    sdaOe,
  output logic                    wrStrobe,
  output logic [7:0]              wrIndex,
  output logic [7:0]              wrData,
  output logic                    statPinOut,
  output logic                    statPinOe,
  output logic                    faultIrq,
  output logic                    boostEnable,
  output supervisorStatus_t       status,
  output logic [LIMIT_W-1:0]      effectiveLimit,
  output logic [15:0]             appliedVoltage,
  output logic [15:0]             appliedCurrent
);
  localparam int CW = $clog2(BLINK_HALF_CYCLES + 1);

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  logic [7:0] rdData, rdIndex;
  logic       rdStrobe, faultRead;

  serial_slave_port u_port (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .rdData   (rdData),
    .rdIndex  (rdIndex),
    .rdStrobe (rdStrobe),
    .wrStrobe (wrStrobe),
    .wrIndex  (wrIndex),
    .wrData   (wrData)
  );

  always_comb begin
    if (rdIndex == `RD_FAULT_IDX) begin
      rdData = {status.boostFaultFlag, status.chargeFaultField, status.batteryFaultFlag,
                1'b0, status.thermistorFaultField};
    end else if (rdIndex == `RD_STATUS_IDX) begin
      rdData = {status.thermalRegulationFlag, status.shippingMode, status.batterySwitchOn,
                status.converterEnable, status.chargeAllow, status.dischargeAllow,
                status.hiccupMode, boostEnable};
    end else begin
      rdData = 8'h00;
    end
  end
  assign faultRead  = rdStrobe && (rdIndex == `RD_FAULT_IDX);
  assign statPinOut = 1'b0;

  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  supervisorStatus_t next_status;
  faultEvents_t      faultPrev;
  logic [CW-1:0]     blinkCnt, next_blinkCnt;
  logic [2:0]        zonePrev;
  logic blinkPhase, next_blinkPhase, next_statPinOe, next_faultIrq, next_boostEnable;
  logic offPrev, wakePrev, adapterPrev, latchOff, next_latchOff, odLatch, next_odLatch;
  logic shipExit, ntcSuspend, suspendAny, inWindow;
  logic [1:0] chargeCode;
  logic [LIMIT_W-1:0] next_effectiveLimit;
  logic [15:0] next_appliedVoltage, next_appliedCurrent;

  always_comb begin
    next_status      = status;
    next_latchOff    = latchOff;
    next_odLatch     = odLatch;
    next_boostEnable = boostEnable;
    shipExit = (adapterPresent && !adapterPrev) || (wakePrev && !wakeRequestPin);
    if (batterySwitchOffCtl && !offPrev) begin
      next_status.shippingMode = 1'b1;
    end else if (shipExit) begin
      next_status.shippingMode = 1'b0;
    end
    if (faults.systemShort) begin
      next_latchOff = 1'b1;
    end else if (shipExit) begin
      next_latchOff = 1'b0;
    end
    if (faults.batteryOverDischarge) begin
      next_odLatch = 1'b1;
    end else if (adapterPresent) begin
      next_odLatch = 1'b0;
    end
    next_status.batterySwitchOn = !next_status.shippingMode && !next_latchOff && !next_odLatch
                                  && !faults.buckShutdown && !faults.boostShutdown;
    next_status.converterEnable = !faults.buckShutdown && !faults.inputOvervoltage
                                  && !faults.systemOvervoltage && !faults.boostOvervoltage;
    if (faults.inputOvervoltage) begin
      chargeCode = `CHG_FAULT_INPUT;
    end else if (faults.buckShutdown) begin
      chargeCode = `CHG_FAULT_THERMAL;
    end else begin
      chargeCode = `CHG_FAULT_NONE;
    end
    if (chargeCode != `CHG_FAULT_NONE) begin
      next_status.chargeFaultField = chargeCode;
    end else if (faultRead) begin
      next_status.chargeFaultField = `CHG_FAULT_NONE;
    end
    if (faults.boostOverCurrent || faults.boostOvervoltage) begin
      next_status.boostFaultFlag = 1'b1;
    end else if (faultRead) begin
      next_status.boostFaultFlag = 1'b0;
    end
    if (faults.batteryOvervoltage) begin
      next_status.batteryFaultFlag = 1'b1;
    end else if (faultRead) begin
      next_status.batteryFaultFlag = 1'b0;
    end
    next_status.thermistorFaultField = thermistorZone;
    if (faults.boostShutdown || faults.boostOvervoltage) begin
      next_boostEnable = 1'b0;
    end else if (boostEnableSet) begin
      next_boostEnable = 1'b1;
    end
    next_status.hiccupMode = boostEnable && faults.boostOverCurrent;
    next_status.thermalRegulationFlag = faults.thermalRegulation;
    next_status.terminationEnable = !faults.thermalRegulation;
    next_status.timerHalfRate = faults.thermalRegulation;
    ntcSuspend = (thermistorZone == `NTC_COLD) || (thermistorZone == `NTC_HOT);
    next_status.chargeAllow = chargeState.chargeEnable && !faults.batteryOvervoltage
                              && !faults.inputOvervoltage && !faults.buckShutdown && !ntcSuspend;
    inWindow = (ntcCode <= dischargeColdThr) && (ntcCode >= dischargeHotThr);
    next_status.dischargeAllow = inWindow;
    next_status.limitMonitorEnable = pinLimitEnable;
    next_faultIrq = (faults.inputOvervoltage && !faultPrev.inputOvervoltage)
                    || (faults.buckShutdown && !faultPrev.buckShutdown)
                    || (faults.boostOverCurrent && !faultPrev.boostOverCurrent)
                    || (faults.boostOvervoltage && !faultPrev.boostOvervoltage)
                    || (faults.batteryOvervoltage && !faultPrev.batteryOvervoltage)
                    || (thermistorZone != zonePrev && thermistorZone != `NTC_NORMAL);
  end

  // ----------------------------------------
  // Limits and charge targets
  // ----------------------------------------
  always_comb begin
    if (!pinLimitEnable || pinGrounded) begin
      next_effectiveLimit = inputLimitSetting;
    end else if (pinOpen) begin
      next_effectiveLimit = '0;
    end else begin
      next_effectiveLimit = (pinLimit < inputLimitSetting) ? pinLimit : inputLimitSetting;
    end
    if (thermistorZone == `NTC_WARM && warmVoltageSel) begin
      next_appliedVoltage = chargeVoltageTarget - `WARM_OFFSET_MV;
    end else begin
      next_appliedVoltage = chargeVoltageTarget;
    end
    if (thermistorZone != `NTC_COOL) begin
      next_appliedCurrent = fastChargeCurrent;
    end else if (coolCurrentSel) begin
      next_appliedCurrent = {1'b0, fastChargeCurrent[15:1]};
    end else begin
      next_appliedCurrent = fastChargeCurrent / 16'h0005;
    end
  end

  // ----------------------------------------
  // Status pin and blink divider
  // ----------------------------------------
  always_comb begin
    next_blinkCnt   = blinkCnt + 1'b1;
    next_blinkPhase = blinkPhase;
    if (blinkCnt == CW'(BLINK_HALF_CYCLES - 1)) begin
      next_blinkCnt   = '0;
      next_blinkPhase = !blinkPhase;
    end
    suspendAny = chargeState.chargeSuspend || chargeState.boostSuspend
                 || (ntcSuspend && (chargeState.charging || !inWindow));
    if (suspendAny) begin
      next_statPinOe = blinkPhase;
    end else begin
      next_statPinOe = chargeState.charging && !chargeState.chargeDone
                       && chargeState.chargeEnable && !chargeState.sleepMode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status         <= '0;
      faultPrev      <= '0;
      zonePrev       <= `NTC_NORMAL;
      blinkCnt       <= '0;
      blinkPhase     <= 1'b0;
      statPinOe      <= 1'b0;
      faultIrq       <= 1'b0;
      boostEnable    <= 1'b0;
      offPrev        <= 1'b0;
      wakePrev       <= 1'b1;
      adapterPrev    <= 1'b0;
      latchOff       <= 1'b0;
      odLatch        <= 1'b0;
      effectiveLimit <= '0;
      appliedVoltage <= 16'h0000;
      appliedCurrent <= 16'h0000;
    end else begin
      status         <= next_status;
      faultPrev      <= faults;
      zonePrev       <= thermistorZone;
      blinkCnt       <= next_blinkCnt;
      blinkPhase     <= next_blinkPhase;
      statPinOe      <= next_statPinOe;
      faultIrq       <= next_faultIrq;
      boostEnable    <= next_boostEnable;
      offPrev        <= batterySwitchOffCtl;
      wakePrev       <= wakeRequestPin;
      adapterPrev    <= adapterPresent;
      latchOff       <= next_latchOff;
      odLatch        <= next_odLatch;
      effectiveLimit <= next_effectiveLimit;
      appliedVoltage <= next_appliedVoltage;
      appliedCurrent <= next_appliedCurrent;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_stat_low;
    @(posedge ref_clk) disable iff (!rst_n)
      (!suspendAny && chargeState.charging && !chargeState.chargeDone && chargeState.chargeEnable
       && !chargeState.sleepMode) |=> statPinOe;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status pin not low while charging");

  property p_stat_blink;
    @(posedge ref_clk) disable iff (!rst_n)
      suspendAny ##1 suspendAny |-> statPinOe == $past(blinkPhase, 1);
  endproperty
  a_stat_blink: assert property (p_stat_blink) else $error("status pin not blinking on suspend");

  property p_ship_enter;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(batterySwitchOffCtl) |=> status.shippingMode && !status.batterySwitchOn;
  endproperty
  a_ship_enter: assert property (p_ship_enter) else $error("shipping mode not entered");

  property p_ship_exit;
    @(posedge ref_clk) disable iff (!rst_n)
      (status.shippingMode && $fell(wakeRequestPin) && !$rose(batterySwitchOffCtl)) |=> !status.shippingMode;
  endproperty
  a_ship_exit: assert property (p_ship_exit) else $error("wake edge did not end shipping mode");

  property p_pin_open;
    @(posedge ref_clk) disable iff (!rst_n)
      (pinLimitEnable && pinOpen && !pinGrounded) |=> effectiveLimit == '0;
  endproperty
  a_pin_open: assert property (p_pin_open) else $error("open limit pin did not force zero");

  property p_buck_tsd;
    @(posedge ref_clk) disable iff (!rst_n)
      (faults.buckShutdown && !faults.inputOvervoltage) |=> status.chargeFaultField == `CHG_FAULT_THERMAL
      && !status.converterEnable && !status.batterySwitchOn;
  endproperty
  a_buck_tsd: assert property (p_buck_tsd) else $error("thermal shutdown response wrong");

  property p_input_ov;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(faults.inputOvervoltage) |=> status.chargeFaultField == `CHG_FAULT_INPUT
      && !status.converterEnable && faultIrq;
  endproperty
  a_input_ov: assert property (p_input_ov) else $error("input over-voltage response wrong");

  property p_boost_ov;
    @(posedge ref_clk) disable iff (!rst_n)
      faults.boostOvervoltage |=> !boostEnable && status.boostFaultFlag;
  endproperty
  a_boost_ov: assert property (p_boost_ov) else $error("boost over-voltage response wrong");

  property p_batt_ov;
    @(posedge ref_clk) disable iff (!rst_n)
      faults.batteryOvervoltage |=> !status.chargeAllow && status.batteryFaultFlag;
  endproperty
  a_batt_ov: assert property (p_batt_ov) else $error("battery over-voltage response wrong");

  property p_discharge;
    @(posedge ref_clk) disable iff (!rst_n)
      (ntcCode > dischargeColdThr) |=> !status.dischargeAllow;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge allowed outside window");
endmodule : charger_fault_status_supervisor

// >>> pkg/charger_supervisor_regs.svh
// Constants of the charger fault and status supervisor
// Assumes inclusion by the package and the design files
`ifndef CHARGER_SUPERVISOR_REGS_SVH
`define CHARGER_SUPERVISOR_REGS_SVH
`define CLK_HZ            40_000_000
`define BLINK_FREQ_HZ     1
`define SLAVE_ADDR        7'h6A
`define CHG_FAULT_NONE    2'h0
`define CHG_FAULT_INPUT   2'h1
`define CHG_FAULT_THERMAL 2'h2
`define NTC_NORMAL        3'h0
`define NTC_WARM          3'h2
`define NTC_COOL          3'h3
`define NTC_COLD          3'h5
`define NTC_HOT           3'h6
`define WARM_OFFSET_MV    16'h0096
`define RD_FAULT_IDX      8'h00
`define RD_STATUS_IDX     8'h01
`endif

// >>> pkg/charger_supervisor_pkg.sv
// Types of the charger fault and status supervisor
// Assumes the constants header sits beside it
`include "charger_supervisor_regs.svh"
package charger_supervisor_pkg;
  typedef struct packed {
    logic buckShutdown;
    logic boostShutdown;
    logic thermalRegulation;
    logic inputOvervoltage;
    logic systemOvervoltage;
    logic boostOverCurrent;
    logic boostOvervoltage;
    logic batteryOvervoltage;
    logic batteryOverDischarge;
    logic systemShort;
  } faultEvents_t;

  typedef struct packed {
    logic charging;
    logic chargeDone;
    logic chargeEnable;
    logic sleepMode;
    logic chargeSuspend;
    logic boostSuspend;
  } chargeState_t;

  typedef struct packed {
    logic       thermalRegulationFlag;
    logic [1:0] chargeFaultField;
    logic       boostFaultFlag;
    logic       batteryFaultFlag;
    logic [2:0] thermistorFaultField;
    logic       converterEnable;
    logic       batterySwitchOn;
    logic       shippingMode;
    logic       chargeAllow;
    logic       terminationEnable;
    logic       timerHalfRate;
    logic       hiccupMode;
    logic       dischargeAllow;
    logic       limitMonitorEnable;
  } supervisorStatus_t;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WBYTE, S_WACK, S_RBYTE, S_RACK} slaveState_t;
endpackage : charger_supervisor_pkg

// >>> core/serial_slave_port.sv
// Two-wire serial slave: address match, byte writes, byte reads
// Assumes scl and sda already synchronous to ref_clk
`timescale 1ns/1ps
module serial_slave_port
  import charger_supervisor_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [7:0] rdData,
  output logic [7:0]      rdIndex,
  output logic            rdStrobe,
  output logic            wrStrobe,
  output logic [7:0]      wrIndex,
  output logic [7:0]      wrData
);
  slaveState_t state, next_state;
  logic       sclPrev, sdaPrev, rw, next_rw, first, next_first;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shift, next_shift, next_rdIndex, next_wrIndex, next_wrData;
  logic       next_sdaOe, next_rdStrobe, next_wrStrobe;
  logic       startC, stopC, rise, fall;

  assign sdaOut = 1'b0;
  assign startC = sclIn && sclPrev && sdaPrev && !sdaIn;
  assign stopC  = sclIn && sclPrev && !sdaPrev && sdaIn;
  assign rise   = sclIn && !sclPrev;
  assign fall   = !sclIn && sclPrev;

  always_comb begin
    next_state    = state;
    next_rw       = rw;
    next_first    = first;
    next_bitCnt   = bitCnt;
    next_shift    = shift;
    next_rdIndex  = rdIndex;
    next_wrIndex  = wrIndex;
    next_wrData   = wrData;
    next_sdaOe    = sdaOe;
    next_rdStrobe = 1'b0;
    next_wrStrobe = 1'b0;
    if (startC) begin
      next_state  = S_ADDR;
      next_bitCnt = 4'h0;
      next_first  = 1'b1;
      next_sdaOe  = 1'b0;
    end else if (stopC) begin
      next_state = S_IDLE;
      next_sdaOe = 1'b0;
    end else begin
      case (state)
        S_ADDR, S_WBYTE: begin
          if (rise) begin
            next_shift  = {shift[6:0], sdaIn};
            next_bitCnt = bitCnt + 4'h1;
          end else if (fall && bitCnt == 4'h8) begin
            if (state == S_WBYTE) begin
              next_state = S_WACK;
              next_sdaOe = 1'b1;
              next_first = 1'b0;
              if (first) begin
                next_rdIndex = shift;
              end else begin
                next_wrStrobe = 1'b1;
                next_wrIndex  = rdIndex;
                next_wrData   = shift;
                next_rdIndex  = rdIndex + 8'h01;
              end
            end else if (shift[7:1] == `SLAVE_ADDR) begin
              next_state = S_AACK;
              next_sdaOe = 1'b1;
              next_rw    = shift[0];
            end else begin
              next_state = S_IDLE;
            end
          end
        end
        S_AACK, S_WACK: begin
          if (fall) begin
            next_bitCnt = 4'h0;
            if (state == S_AACK && rw) begin
              next_state    = S_RBYTE;
              next_shift    = rdData;
              next_sdaOe    = !rdData[7];
              next_rdStrobe = 1'b1;
            end else begin
              next_state = S_WBYTE;
              next_sdaOe = 1'b0;
            end
          end
        end
        S_RBYTE: begin
          if (fall) begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == 4'h7) begin
              next_state   = S_RACK;
              next_sdaOe   = 1'b0;
              next_rdIndex = rdIndex + 8'h01;
            end else begin
              next_sdaOe = !shift[6];
              next_shift = {shift[6:0], 1'b0};
            end
          end
        end
        S_RACK: begin
          if (rise && sdaIn) begin
            next_state = S_IDLE;
          end else if (fall) begin
            next_state    = S_RBYTE;
            next_bitCnt   = 4'h0;
            next_shift    = rdData;
            next_sdaOe    = !rdData[7];
            next_rdStrobe = 1'b1;
          end
        end
        default: begin
          next_state = S_IDLE;
          next_sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= S_IDLE;
      sclPrev  <= 1'b1;
      sdaPrev  <= 1'b1;
      rw       <= 1'b0;
      first    <= 1'b0;
      bitCnt   <= 4'h0;
      shift    <= 8'h00;
      rdIndex  <= 8'h00;
      wrIndex  <= 8'h00;
      wrData   <= 8'h00;
      sdaOe    <= 1'b0;
      rdStrobe <= 1'b0;
      wrStrobe <= 1'b0;
    end else begin
      state    <= next_state;
      sclPrev  <= sclIn;
      sdaPrev  <= sdaIn;
      rw       <= next_rw;
      first    <= next_first;
      bitCnt   <= next_bitCnt;
      shift    <= next_shift;
      rdIndex  <= next_rdIndex;
      wrIndex  <= next_wrIndex;
      wrData   <= next_wrData;
      sdaOe    <= next_sdaOe;
      rdStrobe <= next_rdStrobe;
      wrStrobe <= next_wrStrobe;
    end
  end
endmodule : serial_slave_port

// >>> testbench/serial_host_model.sv
// Host master model of the two-wire serial port
// Assumes a pull-up on sda; the slave pulls low via sdaOe
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic ref_clk,
  input  wire logic sdaOe,
  output wire logic scl,
  output wire logic sda
);
  logic drv = 1'h1, sclLine = 1'h1;
  assign scl = sclLine;
  assign sda = drv & ~sdaOe;
  task automatic phase(input logic c, input logic d);
    sclLine = c;
    drv = d;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : phase
  task automatic frame(input logic s);
    phase(!s, 1'h0);
    phase(s, 1'h0);
    if (s) phase(1'h1, 1'h1);
  endtask : frame
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic [8:0] f = {b, 1'h1};
    for (int i = 8; i >= 0; i--) begin
      phase(1'h0, f[i]);
      phase(1'h1, f[i]);
      ack = !sda;
    end
  endtask : sendByte
endmodule : serial_host_model

// >>> testbench/test_charger_fault_status_supervisor.sv
// Self-checking bench of the charger supervisor
// Assumes the host model drives the serial bus pins
`timescale 1ns/1ps
module test_charger_fault_status_supervisor import charger_supervisor_pkg::*;
;
  logic ref_clk = 1'h0, rst_n = 1'h0, adapterPresent = 1'h0, wakeRequestPin = 1'h1, batterySwitchOffCtl = 1'h0;
  logic boostEnableSet = 1'h0, pinLimitEnable = 1'h1, pinOpen = 1'h0, pinGrounded = 1'h0, warmVoltageSel = 1'h0;
  logic coolCurrentSel = 1'h0, sclIn, sdaIn, sdaOe, wrStrobe, statPinOe, faultIrq, boostEnable, ack, b;
  logic [7:0] pinLimit = 8'h20, inputLimitSetting = 8'h30, ntcCode = 8'h80, dischargeColdThr = 8'hC0;
  logic [7:0] dischargeHotThr = 8'h40, wrIndex, wrData, effectiveLimit;
  logic [15:0] chargeVoltageTarget = '0, fastChargeCurrent = '0, appliedVoltage, appliedCurrent, lastWr;
  logic [2:0] thermistorZone = '0;
  chargeState_t chargeState = '0;
  faultEvents_t faults = '0;
  supervisorStatus_t status;
  int n_errors = 0, compares = 0, irqs = 0;
  charger_fault_status_supervisor #(.BLINK_HALF_CYCLES(8))
    charger_fault_status_supervisor_i (.*, .sdaOut(), .statPinOut());
  serial_host_model serial_host_model_i (.ref_clk, .sdaOe, .scl(sclIn), .sda(sdaIn));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) irqs += (faultIrq === 1'h1);
  always @(posedge ref_clk) if (wrStrobe === 1'h1) lastWr <= {wrIndex, wrData};
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) $display("CHECK FAILED at %0t: %s", $time, what);
    n_errors += (got !== exp);
  endtask : check
  task automatic conclude();
    $display("Counts: compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    #(25 * 9000) n_errors++;
    conclude();
  end
  initial begin
    tick(20);
    rst_n = 1'h1;
    faults.buckShutdown = 1'h1;
    tick(2);
    check(effectiveLimit, 8'h20, "limit");
    check(status.chargeFaultField, 2'h2, "thermal");
    faults.inputOvervoltage = 1'h1;
    pinOpen = 1'h1;
    tick(2);
    check(status.chargeFaultField, 2'h1, "input ov");
    check(irqs, 2, "irq count");
    check(effectiveLimit, 8'h00, "open pin");
    faults = '0;
    batterySwitchOffCtl = 1'h1;
    chargeState = 6'h28;
    tick(2);
    check(status.shippingMode, 1'h1, "ship");
    check(statPinOe, 1'h1, "charging");
    wakeRequestPin = 1'h0;
    chargeState.chargeSuspend = 1'h1;
    tick(2);
    check(status.batterySwitchOn, 1'h1, "wake");
    b = statPinOe;
    tick(8);
    check(statPinOe, !b, "blink");
    $display("Test protection done");
    chargeVoltageTarget = 16'h1068;
    fastChargeCurrent = 16'h0800;
    thermistorZone = 3'h2;
    warmVoltageSel = 1'h1;
    tick(2);
    check(appliedVoltage, 16'h0FD2, "warm voltage");
    thermistorZone = 3'h3;
    tick(2);
    check(appliedCurrent, 16'h0199, "cool fifth");
    coolCurrentSel = 1'h1;
    tick(2);
    check(appliedCurrent, 16'h0400, "cool half");
    boostEnableSet = 1'h1;
    tick(2);
    boostEnableSet = 1'h0;
    check(boostEnable, 1'h1, "boost on");
    faults.boostShutdown = 1'h1;
    tick(2);
    check(boostEnable, 1'h0, "boost shutdown");
    faults.boostShutdown = 1'h0;
    tick(2);
    check(boostEnable, 1'h0, "boost stays off");
    boostEnableSet = 1'h1;
    tick(2);
    boostEnableSet = 1'h0;
    check(boostEnable, 1'h1, "boost re-enabled");
    $display("Test targets done");
    serial_host_model_i.frame(1'h0);
    serial_host_model_i.sendByte(8'hD4, ack);
    check(ack, 1'h1, "address ack");
    serial_host_model_i.sendByte(8'h05, ack);
    serial_host_model_i.sendByte(8'hA5, ack);
    serial_host_model_i.frame(1'h1);
    check(lastWr, 16'h05A5, "write");
    $display("Test serial done");
    conclude();
  end
endmodule : test_charger_fault_status_supervisor
